//--- design/mdt_pkg.sv
// Shared constants and types for the multimode delay timer
// Overview of operation
// - The timer reset input stops timing, clears the elapsed count and turns the control output off.
// - While the gate input is active the elapsed count holds, and counting resumes on its release.
// - When the elapsed count reaches the preset the control output switches as the selected mode defines.
// - In one-shot mode a single output pulse follows each start with a nonzero preset, however long start is held; a zero preset gives no pulse.
// - A zero target (in two-phase mode both phases zero) puts the output at once at its after-preset level, with no delay.
// - In the two-phase mode the total set time is the first phase plus the second phase.
// - Start and timer reset keep working while the gate input is active.
package mdt_pkg;

   // Main clock and the time base derived from it
   localparam int unsigned CLK_HZ       = 25_000_000;
   localparam int unsigned TIME_UNIT_MS = 10;
   localparam int unsigned MS_PER_S     = 1000;
   localparam int unsigned UNIT_CYCLES  = (CLK_HZ / MS_PER_S) * TIME_UNIT_MS;

   // Least pulse width the outside source must give
   localparam int unsigned MIN_PULSE_MS     = 50;
   localparam int unsigned MIN_PULSE_CYCLES = ((CLK_HZ / MS_PER_S) * MIN_PULSE_MS);

   // Width of the preset and phase fields, in time units
   localparam int unsigned PRESET_W = 16;

   // Operating modes
   typedef enum logic [1:0]
   {
      MDT_ON_DELAY  = 2'b00,
      MDT_INTERVAL  = 2'b01,
      MDT_ONE_SHOT  = 2'b10,
      MDT_SUM_DELAY = 2'b11
   } mdt_mode_type;

   // Timing phases
   typedef enum logic [1:0]
   {
      MDT_PH_IDLE   = 2'b00,
      MDT_PH_TIMING = 2'b01,
      MDT_PH_DONE   = 2'b10
   } mdt_phase_type;

endpackage

//--- design/mdt_tick_if.sv
// Time base link between the timer core and its prescaler
`timescale 1ns/10ps
interface mdt_tick_if;
   logic clear;
   logic enable;
   logic tick;

   // Core side drives the prescaler controls
   modport ctl (output clear, output enable, input tick);
   // Prescaler side answers with the tick
   modport pre (input clear, input enable, output tick);
endinterface

//--- design/mdt_prescaler.sv
// Prescaler that turns the main clock into one-cycle time-unit ticks
`timescale 1ns/10ps
module mdt_prescaler
#(
   parameter int unsigned DIV = mdt_pkg::UNIT_CYCLES
)
(
   // Clock and reset
   input  wire logic   sys_clk_in,
   input  wire logic   rst_in,
   // Tick link
   mdt_tick_if.pre     tick_if
);
   import mdt_pkg::*;

   localparam int unsigned CNT_W = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);

   typedef struct packed
   {
      logic [CNT_W-1:0] cnt;
   } mdt_pre_state_type;

   mdt_pre_state_type q;
   mdt_pre_state_type d;

   // Tick only while enabled; a clear restarts the unit so each timing starts on a whole unit
   assign tick_if.tick = tick_if.enable & ~tick_if.clear & (q.cnt == LAST);

   // Next count
   always_comb
   begin
      d = q;
      if (tick_if.clear)
      begin
         d.cnt = '0;
      end
      else if (tick_if.enable)
      begin
         if (q.cnt == LAST)
         begin
            d.cnt = '0;
         end
         else
         begin
            d.cnt = q.cnt + 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end
endmodule

//--- design/mdt_timer.sv
// Multimode delay timer core: start, timer reset and gate inputs, one control output
`timescale 1ns/10ps
module mdt_timer
#(
   parameter int unsigned UNIT_CYCLES = mdt_pkg::UNIT_CYCLES,
   parameter int unsigned PRESET_W    = mdt_pkg::PRESET_W
)
(
   // Clock and reset
   input  wire logic                  sys_clk_in,
   input  wire logic                  rst_in,
   // Contact and sensor inputs
   input  wire logic                  start_in,
   input  wire logic                  timer_reset_in,
   input  wire logic                  gate_in,
   // Dial settings
   input  wire mdt_pkg::mdt_mode_type mode_in,
   input  wire logic [PRESET_W-1:0]   preset_in,
   input  wire logic [PRESET_W-1:0]   preset2_in,
   // Load and status
   output logic                       ctrl_out,
   output logic                       timing_out,
   output logic [PRESET_W:0]          elapsed_out
);
   import mdt_pkg::*;

   typedef struct packed
   {
      mdt_phase_type       phase;
      logic [PRESET_W:0]   elapsed;
      logic                ctrl;
      logic                start_prev;
   } mdt_state_type;

   localparam mdt_state_type RST_STATE = '{phase: MDT_PH_IDLE, elapsed: '0, ctrl: 1'b0, start_prev: 1'b0};

   mdt_state_type       q;
   mdt_state_type       d;
   mdt_tick_if          tick_if ();
   logic                start_edge;
   logic [PRESET_W:0]   target;
   logic [PRESET_W:0]   elapsed_inc;
   logic                level_at_start;
   logic                level_at_done;

   ////////////////////////////////////////////////////////////////////////////////
   // Time base

   mdt_prescaler
   #(
      .DIV        (UNIT_CYCLES)
   )
   u_prescaler
   (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .tick_if    (tick_if)
   );

   // Clear on every restart; run only while timing and not gated
   assign tick_if.clear  = timer_reset_in | start_edge;
   assign tick_if.enable = (q.phase == MDT_PH_TIMING) & ~gate_in;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode of settings

   // Edge detect so a held start counts once
   assign start_edge  = start_in & ~q.start_prev;
   assign elapsed_inc = q.elapsed + 1'b1;

   // Target time: two-phase mode adds both phases, carry kept in the extra bit
   always_comb
   begin
      if (mode_in == MDT_SUM_DELAY)
      begin
         target = {1'b0, preset_in} + {1'b0, preset2_in};
      end
      else
      begin
         target = {1'b0, preset_in};
      end
   end

   // Output level while timing and after the preset is reached
   always_comb
   begin
      level_at_start = 1'b0;
      level_at_done  = 1'b0;
      unique case (mode_in)
         MDT_ON_DELAY:  level_at_done  = 1'b1;
         MDT_INTERVAL:  level_at_start = 1'b1;
         MDT_ONE_SHOT:  level_at_start = 1'b1;
         MDT_SUM_DELAY: level_at_done  = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencing

   // Timer reset beats start; start beats a tick in the same cycle
   always_comb
   begin
      d            = q;
      d.start_prev = start_in;
      if (timer_reset_in)
      begin
         d.phase   = MDT_PH_IDLE;
         d.elapsed = '0;
         d.ctrl    = 1'b0;
      end
      else if (start_edge)
      begin
         d.elapsed = '0;
         if (target == '0)
         begin
            d.phase = MDT_PH_DONE;
            d.ctrl  = level_at_done;
         end
         else
         begin
            d.phase = MDT_PH_TIMING;
            d.ctrl  = level_at_start;
         end
      end
      else if ((q.phase == MDT_PH_TIMING) && tick_if.tick)
      begin
         if (elapsed_inc >= target)
         begin
            d.phase   = MDT_PH_DONE;
            d.elapsed = target;
            d.ctrl    = level_at_done;
         end
         else
         begin
            d.elapsed = elapsed_inc;
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         q <= RST_STATE;
      end
      else
      begin
         q <= d;
      end
   end

   // Outputs straight from the state flip-flops
   assign ctrl_out    = q.ctrl;
   assign timing_out  = (q.phase == MDT_PH_TIMING);
   assign elapsed_out = q.elapsed;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   // Start with a nonzero target begins from zero
   chk_start_begins_count: assert property (
      (start_edge && !timer_reset_in && target != '0) |=> (timing_out && elapsed_out == '0))
      else $error("start did not begin timing from zero");

   // Timer reset clears everything and holds while asserted
   chk_reset_clears_all: assert property (
      timer_reset_in |=> (!ctrl_out && !timing_out && elapsed_out == '0))
      else $error("timer reset left output or count set");

   // Gated count stays put over two cycles
   chk_gate_holds_count: assert property (
      (gate_in && !timer_reset_in && !start_edge) [*2] |=> $stable(elapsed_out))
      else $error("count moved while gated");

   // Reaching the preset in on-delay turns the output on
   chk_preset_turns_on: assert property (
      (timing_out && tick_if.tick && elapsed_inc >= target && !timer_reset_in && !start_edge
       && mode_in == MDT_ON_DELAY) |=> (ctrl_out && !timing_out))
      else $error("output not on at preset");

   // One-shot: held start after the pulse never gives a second one
   chk_one_pulse_per_start: assert property (
      (q.phase == MDT_PH_DONE && mode_in == MDT_ONE_SHOT && start_in && q.start_prev && !ctrl_out)
      |=> !ctrl_out)
      else $error("second one-shot pulse without a new start");

   // Zero preset switches on the very next edge
   chk_zero_is_instant: assert property (
      (start_edge && !timer_reset_in && target == '0 && level_at_done) |=> (ctrl_out && !timing_out))
      else $error("zero preset did not switch at once");

   // Two-phase mode keeps timing past the first phase alone
   chk_sum_past_phase1: assert property (
      (timing_out && tick_if.tick && mode_in == MDT_SUM_DELAY && elapsed_inc == {1'b0, preset_in}
       && preset2_in != '0 && !timer_reset_in && !start_edge) |=> (timing_out && !ctrl_out))
      else $error("two-phase mode stopped at first phase");

   // Start still works under the gate
   chk_gate_keeps_start: assert property (
      (gate_in && start_edge && !timer_reset_in && target != '0) |=> (timing_out && elapsed_out == '0))
      else $error("start ignored while gated");

   // Timer reset still works under the gate, and the output falls
   chk_gate_keeps_reset: assert property (
      (gate_in && timer_reset_in && ctrl_out) |=> $fell(ctrl_out))
      else $error("timer reset ignored while gated");

   // Interval mode switches the output on as timing starts
   chk_interval_on_start: assert property (
      (start_edge && !timer_reset_in && target != '0 && mode_in == MDT_INTERVAL) |=> (ctrl_out && timing_out))
      else $error("interval output not on at start");

   // Scenarios worth seeing
   cov_on_delay_done:  cover property (timing_out && mode_in == MDT_ON_DELAY ##1 ctrl_out);
   cov_one_shot_ends:  cover property (mode_in == MDT_ONE_SHOT && $fell(ctrl_out) && start_in);
   cov_gated_timing:   cover property (timing_out && gate_in ##1 timing_out && !gate_in);
   cov_zero_preset:    cover property (start_edge && target == '0);
   cov_sum_done:       cover property (mode_in == MDT_SUM_DELAY && $rose(ctrl_out));
endmodule

//--- tb/mdt_contacts.sv
// Contact source model for the start and timer reset inputs
`timescale 1ns/10ps
module mdt_contacts
#(
   parameter int unsigned HOLD = 20
)
(
   // Clock
   input  wire logic sys_clk_in,
   // Pulse requests from the bench
   input  wire logic start_req_in,
   input  wire logic reset_req_in,
   // Contact levels
   output logic      start_out,
   output logic      reset_out
);
   int s_cnt = 0;
   int r_cnt = 0;

   // Each request closes a contact for HOLD cycles, the least width the timer must see
   always @(posedge sys_clk_in)
   begin
      s_cnt <= start_req_in ? HOLD : (s_cnt > 0 ? s_cnt - 1 : 0);
      r_cnt <= reset_req_in ? HOLD : (r_cnt > 0 ? r_cnt - 1 : 0);
   end

   assign start_out = (s_cnt != 0);
   assign reset_out = (r_cnt != 0);
endmodule

//--- tb/multimode_delay_timer_bench.sv
// Self-checking bench for the multimode delay timer core
`timescale 1ns/10ps
module multimode_delay_timer_bench;
   import mdt_pkg::*;
   localparam int unsigned U = 4;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        start_req = 1'b0;
   logic        reset_req = 1'b0;
   logic        gate = 1'b0;
   mdt_mode_type mode = MDT_ON_DELAY;
   logic [15:0] p1 = 16'h0000;
   logic [15:0] p2 = 16'h0000;
   logic        start;
   logic        treset;
   logic        ctrl;
   logic        timing;
   logic [16:0] elapsed;
   logic [16:0] snap;
   int          mismatches = 0;
   int          tests_run = 0;
   int          cycles = 0;

   // Clock at 25 MHz
   always #20 clk = ~clk;

   mdt_contacts #(.HOLD(5 * U)) mdt_contacts_i
   (
      .sys_clk_in   (clk),
      .start_req_in (start_req),
      .reset_req_in (reset_req),
      .start_out    (start),
      .reset_out    (treset)
   );

   mdt_timer #(.UNIT_CYCLES(U)) mdt_timer_i
   (
      .sys_clk_in     (clk),
      .rst_in         (rst),
      .start_in       (start),
      .timer_reset_in (treset),
      .gate_in        (gate),
      .mode_in        (mode),
      .preset_in      (p1),
      .preset2_in     (p2),
      .ctrl_out       (ctrl),
      .timing_out     (timing),
      .elapsed_out    (elapsed)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One-cycle request; the contact model stretches it, answer settles two edges later
   task automatic pulse(input logic rs);
      @(posedge clk);
      if (rs)
         reset_req <= 1'b1;
      else
         start_req <= 1'b1;
      @(posedge clk);
      reset_req <= 1'b0;
      start_req <= 1'b0;
      cyc(2);
      #1;
   endtask

   // Interval and one-shot drive the output while timing, the others after it
   task automatic run_mode(input logic [1:0] m, input logic [15:0] a, input logic [15:0] b);
      logic [16:0] t;
      logic        on_while;
      t = (m == 2'b11) ? ({1'b0, a} + {1'b0, b}) : {1'b0, a};
      on_while = m[1] ^ m[0];
      @(posedge clk);
      mode <= mdt_mode_type'(m);
      p1 <= a;
      p2 <= b;
      pulse(1'b0);
      check(timing, (t != 0));
      check(ctrl, (t != 0) ? on_while : !on_while);
      // Soon after completion, while a short run's start is still held: no retrigger
      cyc(t * U + 4);
      #1;
      check(ctrl, !on_while);
      cyc(20);
      #1;
      check(timing, 17'h0_0000);
      check(elapsed, t);
      check(ctrl, !on_while);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles >= 20000)
      begin
         mismatches++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      void'($urandom(32'h9fa6));
      cyc(3);
      rst <= 1'b0;
      // Zero targets and a long start in one-shot mode first
      run_mode(2'b10, 16'h0000, 16'h0000);
      run_mode(2'b11, 16'h0000, 16'h0000);
      run_mode(2'b10, 16'h0001, 16'h0000);
      run_mode(2'b11, 16'h0002, 16'h0003);
      // Interval and plain on-delay with nonzero presets, whatever the seed gives
      run_mode(2'b01, 16'h0003, 16'h0000);
      run_mode(2'b00, 16'h0004, 16'h0000);
      for (int i = 0; i < 12; i++)
         run_mode(2'($urandom % 4), 16'($urandom % 5), 16'($urandom % 3));
      // Gate freezes the count while start and reset stay live
      run_mode(2'b00, 16'h0000, 16'h0000);
      @(posedge clk);
      p1 <= 16'h0006;
      pulse(1'b0);
      cyc(10);
      gate <= 1'b1;
      cyc(2);
      #1;
      snap = elapsed;
      cyc(30);
      #1;
      check(elapsed, snap);
      check(timing, 17'h0_0001);
      pulse(1'b1);
      check(elapsed, 17'h0_0000);
      check(ctrl, 17'h0_0000);
      check(timing, 17'h0_0000);
      cyc(22);
      pulse(1'b0);
      check(timing, 17'h0_0001);
      @(posedge clk);
      gate <= 1'b0;
      cyc(6 * U + 24);
      #1;
      check(elapsed, 17'h0_0006);
      check(ctrl, 17'h0_0001);
      // Final timer reset under the gate, with the output on
      @(posedge clk);
      gate <= 1'b1;
      pulse(1'b1);
      check(ctrl, 17'h0_0000);
      wrap_up();
   end
endmodule
